// file: hw/periodic_timer.sv
// 10-bit periodic timer with compare, capture, pwm, single pulse and timer modes
// Functional notes
// - mode field picks one of four modes
// - clear_select low: period match clears, both flags
// - clear_select high: duty match clears, duty flag
// - zero duty: overflow at 3FF, no duty flag
// - compare mode: only duty match and timer_on rise move pin
// - pin action: none, low, high or toggle
// - timer_on rise loads initial pin level
// - timer mode: counts like compare, pin undriven
// - pwm period from period value, zero=1024
// - duty at or above period: always active
// - pwm raises duty and period flags
// - output_control polarity; pin action enables/forces pin
// - forced pin keeps counter and comparators running
// - single pulse starts on timer_on rise
// - trigger pin edge sets timer_on
// - duty match or clear ends pulse
// - single pulse: counter zeroed only at start
// - capture edge select; code 11 no capture
// - capture latches counter into duty, raises flag
// - capture: period match clears counter, flags
// - latch within a tick, flag after
// - period split low byte, high two bits
// - capture_source_select picks capture pin
// - output_polarity inverts pin, not timer or capture mode
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module periodic_timer
   import periodic_timer_pkg::*;
(
   input  wire logic        i_clk,                  // 50 MHz system clock
   input  wire logic        i_resetn,               // async reset, active low
   input  wire addr_t       i_avs_address,          // byte address
   input  wire logic        i_avs_read,             // read request
   input  wire logic        i_avs_write,            // write request
   input  wire word_t       i_avs_writedata,        // write data
   input  wire logic [3:0]  i_avs_byteenable,       // byte lanes
   output logic             o_avs_waitrequest,      // stall
   output word_t            o_avs_readdata,         // read data
   input  wire logic        i_capture_input_pin,    // capture input
   input  wire logic        i_ext_clock_trigger_pin,// trigger / alt capture
   output logic             o_waveform_output_pin,  // pin level
   output logic             o_waveform_output_oe    // high while driving
);

   ctrl_t      ctrl_q;
   count_t     duty_q;
   count_t     period_q;
   count_t     cnt_q;
   logic [7:0] prescale_q;
   logic [7:0] div_q;
   logic       ton_q;
   logic       ton_prev_q;
   logic       duty_flag_q;
   logic       period_flag_q;
   logic       pin_q;
   logic       ack_q;
   word_t      rdata_q;
   logic       cap_prev_q;
   logic       trig_prev_q;
   logic       cap_pend_q;
   logic       cap_flag_q;

   logic   tick;
   logic   run;
   logic   ton_rise;
   logic   sp_mode;
   logic   cm_like;
   logic   pwm_wave;
   logic   duty_hit;
   logic   per_hit;
   logic   clr;
   logic   set_dflag;
   logic   set_pflag;
   logic   cap_src;
   logic   cap_edge;
   logic   trig_rise;
   logic   wr_en;
   logic   pwm_active;
   count_t cnt_inc;

   // one wait state: request taken at the edge where ack_q is high
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
   assign o_avs_readdata    = rdata_q;
   assign wr_en             = i_avs_write & ack_q & i_avs_byteenable[0];

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ack_q <= 1'b0;
      else
         ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rdata_q <= '0;
      else if (i_avs_read & ~ack_q)
      begin
         case (i_avs_address)
            ADDR_RUN:       rdata_q <= {31'h0, ton_q};
            ADDR_CTRL:      rdata_q <= {24'h0, ctrl_q};
            ADDR_DUTY_LO:   rdata_q <= {24'h0, duty_q[7:0]};
            ADDR_DUTY_HI:   rdata_q <= {30'h0, duty_q[9:8]};
            ADDR_PERIOD_LO: rdata_q <= {24'h0, period_q[7:0]};
            ADDR_PERIOD_HI: rdata_q <= {30'h0, period_q[9:8]};
            ADDR_COUNT_LO:  rdata_q <= {24'h0, cnt_q[7:0]};
            ADDR_COUNT_HI:  rdata_q <= {30'h0, cnt_q[9:8]};
            ADDR_STATUS:    rdata_q <= {30'h0, period_flag_q, duty_flag_q};
            ADDR_PRESCALE:  rdata_q <= {24'h0, prescale_q};
            default:        rdata_q <= '0;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ctrl_q     <= CTRL_RESET;
         prescale_q <= PRESCALE_RESET;
         period_q   <= COUNT_RESET;
      end
      else if (wr_en)
      begin
         if (i_avs_address == ADDR_CTRL)
            ctrl_q <= ctrl_t'(i_avs_writedata[7:0]);
         if (i_avs_address == ADDR_PRESCALE)
            prescale_q <= i_avs_writedata[7:0];
         if (i_avs_address == ADDR_PERIOD_LO)
            period_q[7:0] <= i_avs_writedata[7:0];
         if (i_avs_address == ADDR_PERIOD_HI)
            period_q[9:8] <= i_avs_writedata[1:0];
      end
   end

   // timer clock enable from the prescaler, divide by prescale_q + 1
   assign tick = (div_q == prescale_q);

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         div_q <= 8'h00;
      else if (tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   always_comb
   begin
      sp_mode    = (ctrl_q.mode == MODE_PWM) && (ctrl_q.pin_action == PA_TOGGLE_OR_OFF);
      cm_like    = (ctrl_q.mode == MODE_COMPARE) || (ctrl_q.mode == MODE_TIMER);
      pwm_wave   = (ctrl_q.mode == MODE_PWM) && !sp_mode;
      ton_rise   = ton_q & ~ton_prev_q;
      run        = ton_q & tick;
      cnt_inc    = cnt_q + 10'h001;
      // compare against the value the counter steps to on this tick
      duty_hit   = (duty_q != COUNT_RESET) && (cnt_inc == duty_q);
      per_hit    = (cnt_inc == period_q);
      // duty at or above period holds active even if the counter overran a lowered period
      pwm_active = ton_q && ((cnt_q < duty_q) ||
                             (period_q != COUNT_RESET && duty_q >= period_q));
      clr        = 1'b0;
      set_dflag  = 1'b0;
      set_pflag  = 1'b0;
      if (cm_like)
      begin
         clr       = ctrl_q.clear_select ? duty_hit : per_hit;
         set_dflag = duty_hit;
         set_pflag = per_hit && !ctrl_q.clear_select;
      end
      else if (ctrl_q.mode == MODE_CAPTURE)
      begin
         clr       = per_hit;
         set_pflag = per_hit;
      end
      else if (sp_mode)
         set_dflag = duty_hit;
      else
      begin
         clr       = per_hit;
         set_dflag = duty_hit;
         set_pflag = per_hit;
      end
   end

   // both pins are already synchronous to i_clk
   assign cap_src   = ctrl_q.capture_source_select ? i_ext_clock_trigger_pin
                                                   : i_capture_input_pin;
   assign trig_rise = i_ext_clock_trigger_pin & ~trig_prev_q;

   always_comb
   begin
      case (ctrl_q.pin_action)
         PA_NONE_OR_RISE:  cap_edge = cap_src & ~cap_prev_q;
         PA_LOW_OR_FALL:   cap_edge = ~cap_src & cap_prev_q;
         PA_HIGH_OR_BOTH:  cap_edge = cap_src ^ cap_prev_q;
         default:          cap_edge = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cap_prev_q  <= 1'b0;
         trig_prev_q <= 1'b0;
         ton_prev_q  <= 1'b0;
      end
      else
      begin
         cap_prev_q  <= cap_src;
         trig_prev_q <= i_ext_clock_trigger_pin;
         ton_prev_q  <= ton_q;
      end
   end

   // software write last; hardware set and stop take precedence
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ton_q <= 1'b0;
      else if (sp_mode && run && duty_hit)
         ton_q <= 1'b0;
      else if (sp_mode && trig_rise)
         ton_q <= 1'b1;
      else if (wr_en && i_avs_address == ADDR_RUN)
         ton_q <= i_avs_writedata[TIMER_ON_BIT];
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         cnt_q <= COUNT_RESET;
      else if (ton_rise)
         cnt_q <= COUNT_RESET;
      else if (run)
         cnt_q <= clr ? COUNT_RESET : cnt_inc;
   end

   // edge waits for the next tick, so the latch lands within one timer clock
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         cap_pend_q <= 1'b0;
      else if (ctrl_q.mode != MODE_CAPTURE || !ton_q)
         cap_pend_q <= 1'b0;
      else if (cap_edge)
         cap_pend_q <= 1'b1;
      else if (tick)
         cap_pend_q <= 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         cap_flag_q <= 1'b0;
      else
         cap_flag_q <= cap_pend_q & tick;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         duty_q <= COUNT_RESET;
      else if (cap_pend_q && tick)
         duty_q <= cnt_q;
      else if (wr_en && i_avs_address == ADDR_DUTY_LO)
         duty_q[7:0] <= i_avs_writedata[7:0];
      else if (wr_en && i_avs_address == ADDR_DUTY_HI)
         duty_q[9:8] <= i_avs_writedata[1:0];
   end

   // write one to clear; a set in the same cycle wins
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         duty_flag_q   <= 1'b0;
         period_flag_q <= 1'b0;
      end
      else
      begin
         if ((run && set_dflag) || cap_flag_q)
            duty_flag_q <= 1'b1;
         else if (wr_en && i_avs_address == ADDR_STATUS && i_avs_writedata[DUTY_FLAG_BIT])
            duty_flag_q <= 1'b0;
         if (run && set_pflag)
            period_flag_q <= 1'b1;
         else if (wr_en && i_avs_address == ADDR_STATUS && i_avs_writedata[PERIOD_FLAG_BIT])
            period_flag_q <= 1'b0;
      end
   end

   // pin level before polarity
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         pin_q <= 1'b0;
      else if (ctrl_q.mode == MODE_COMPARE)
      begin
         if (ton_rise)
            pin_q <= ctrl_q.output_control;
         else if (run && duty_hit)
         begin
            case (ctrl_q.pin_action)
               PA_LOW_OR_FALL:   pin_q <= 1'b0;
               PA_HIGH_OR_BOTH:  pin_q <= 1'b1;
               PA_TOGGLE_OR_OFF: pin_q <= ~pin_q;
               default:          pin_q <= pin_q;
            endcase
         end
      end
      else if (sp_mode)
         pin_q <= ton_q ? ctrl_q.output_control : ~ctrl_q.output_control;
      else if (pwm_wave)
      begin
         case (ctrl_q.pin_action)
            PA_NONE_OR_RISE: pin_q <= ~ctrl_q.output_control;
            PA_LOW_OR_FALL:  pin_q <= ctrl_q.output_control;
            default:         pin_q <= pwm_active ? ctrl_q.output_control
                                                 : ~ctrl_q.output_control;
         endcase
      end
   end

   // pin is released in timer and capture modes for other uses
   assign o_waveform_output_oe  = (ctrl_q.mode == MODE_COMPARE) ||
                                  (ctrl_q.mode == MODE_PWM);
   assign o_waveform_output_pin = pin_q ^ (ctrl_q.output_polarity & o_waveform_output_oe);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence cap_take_s;
      cap_pend_q && tick;
   endsequence

   sequence cap_done_s;
      (duty_q == $past(cnt_q)) ##1 duty_flag_q;
   endsequence

   a_period_clear: assert property (cm_like && !ctrl_q.clear_select && run && per_hit
      && !ton_rise |=> cnt_q == COUNT_RESET && period_flag_q)
      else $error("period match did not clear counter");

   a_duty_clear: assert property (cm_like && ctrl_q.clear_select && run && duty_hit
      && !ton_rise |=> cnt_q == COUNT_RESET)
      else $error("duty match did not clear counter");

   a_no_period_flag: assert property (cm_like && ctrl_q.clear_select && !period_flag_q
      |=> !period_flag_q)
      else $error("period flag raised with clear_select high");

   a_zero_duty_wrap: assert property (cm_like && duty_q == COUNT_RESET && run
      && cnt_q == COUNT_MAX && !duty_flag_q |=> cnt_q == COUNT_RESET && !duty_flag_q)
      else $error("zero duty overflow misbehaved");

   a_initial_level: assert property (ctrl_q.mode == MODE_COMPARE && ton_rise && !wr_en
      |=> pin_q == $past(ctrl_q.output_control))
      else $error("initial pin level wrong");

   a_timer_no_drive: assert property (ctrl_q.mode == MODE_TIMER
      |-> !o_waveform_output_oe)
      else $error("pin driven in timer mode");

   a_pwm_full_duty: assert property (pwm_wave && ctrl_q.pin_action == PA_HIGH_OR_BOTH
      && ton_q && period_q != COUNT_RESET && duty_q >= period_q && !wr_en
      |=> pin_q == $past(ctrl_q.output_control))
      else $error("full duty not held active");

   a_pwm_period: assert property (pwm_wave && run && per_hit && !ton_rise
      |=> cnt_q == COUNT_RESET && period_flag_q)
      else $error("pwm period not closed");

   a_pulse_stop: assert property (sp_mode && run && duty_hit
      |=> !ton_q && duty_flag_q)
      else $error("single pulse not ended by duty match");

   a_capture_seq: assert property ((cap_take_s and !wr_en) |=> cap_done_s)
      else $error("capture latch or flag missing");

   a_capture_off: assert property (ctrl_q.pin_action == PA_TOGGLE_OR_OFF && !cap_pend_q
      |=> !cap_pend_q)
      else $error("capture taken with edge select off");

endmodule // periodic_timer

// file: hw/periodic_timer_pkg.sv
// constants, types and register map of the periodic timer
package periodic_timer_pkg;

   localparam int unsigned CNT_W        = 10;
   localparam int unsigned ADDR_W       = 6;
   localparam int unsigned DATA_W       = 32;

   typedef logic [CNT_W-1:0]  count_t;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] word_t;

   // register byte addresses
   localparam addr_t ADDR_RUN           = 6'h00;
   localparam addr_t ADDR_CTRL          = 6'h04;
   localparam addr_t ADDR_DUTY_LO       = 6'h08;
   localparam addr_t ADDR_DUTY_HI       = 6'h0C;
   localparam addr_t ADDR_PERIOD_LO     = 6'h10;
   localparam addr_t ADDR_PERIOD_HI     = 6'h14;
   localparam addr_t ADDR_COUNT_LO      = 6'h18;
   localparam addr_t ADDR_COUNT_HI      = 6'h1C;
   localparam addr_t ADDR_STATUS        = 6'h20;
   localparam addr_t ADDR_PRESCALE      = 6'h24;

   // bit positions
   localparam int unsigned TIMER_ON_BIT = 0;
   localparam int unsigned DUTY_FLAG_BIT   = 0;
   localparam int unsigned PERIOD_FLAG_BIT = 1;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'h0,
      MODE_CAPTURE = 2'h1,
      MODE_PWM     = 2'h2,
      MODE_TIMER   = 2'h3
   } mode_t;

   // pin action field codes
   localparam logic [1:0] PA_NONE_OR_RISE  = 2'h0;
   localparam logic [1:0] PA_LOW_OR_FALL   = 2'h1;
   localparam logic [1:0] PA_HIGH_OR_BOTH  = 2'h2;
   localparam logic [1:0] PA_TOGGLE_OR_OFF = 2'h3;

   typedef struct packed {
      mode_t      mode;             // mode_select_hi, mode_select_lo
      logic [1:0] pin_action;       // pin_action_hi, pin_action_lo
      logic       output_control;
      logic       output_polarity;
      logic       capture_source_select;
      logic       clear_select;
   } ctrl_t;

   localparam ctrl_t  CTRL_RESET     = '0;
   localparam count_t COUNT_RESET    = 10'h000;
   localparam count_t COUNT_MAX      = 10'h3FF;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;

endpackage

// file: tb/periodic_timer_far_side.sv
// far-side model: capture and trigger sources, waveform pin timing
`timescale 1ns/10ps
module periodic_timer_far_side
(
   input  wire logic i_clk,      // system clock
   input  wire logic i_cap_lvl,  // wanted capture level
   input  wire logic i_trig_lvl, // wanted trigger level
   input  wire logic i_pin,      // waveform pin
   input  wire logic i_oe,       // pin driven
   output logic      o_cap,      // capture input pin
   output logic      o_trig,     // trigger pin
   output int        o_gap,      // clocks between last two changes
   output int        o_high,     // last high width
   output int        o_per,      // last rise to rise
   output int        o_rises     // rises seen
);
   int   cyc_q;
   int   chg_q;
   int   rise_q;
   logic pin_q;

   initial
   begin
      o_cap = 1'b0;
      o_trig = 1'b0;
      pin_q = 1'b0;
      cyc_q = 0;
      chg_q = 0;
      rise_q = 0;
      o_gap = 0;
      o_high = 0;
      o_per = 0;
      o_rises = 0;
   end

   // sources change just after the edge, like a synchronous driver
   always @(posedge i_clk)
   begin
      o_cap <= i_cap_lvl;
      o_trig <= i_trig_lvl;
      cyc_q <= cyc_q + 1;
      // undriven pin is not timed
      if (i_oe === 1'b1 && i_pin !== pin_q)
      begin
         pin_q <= i_pin;
         o_gap <= cyc_q - chg_q;
         chg_q <= cyc_q;
         if (i_pin === 1'b1)
         begin
            o_per <= cyc_q - rise_q;
            rise_q <= cyc_q;
            o_rises <= o_rises + 1;
         end
         else
            o_high <= cyc_q - rise_q;
      end
   end
endmodule // periodic_timer_far_side

// file: tb/test_periodic_timer.sv
// self-checking bench for the periodic timer
`timescale 1ns/10ps
module test_periodic_timer
   import periodic_timer_pkg::*;
;
   logic       i_clk;
   logic       i_resetn;
   addr_t      address;
   logic       read;
   logic       write;
   word_t      writedata;
   logic [3:0] byteenable;
   logic       waitrequest;
   word_t      readdata;
   logic       pin;
   logic       oe;
   logic       cap;
   logic       trig;
   logic       cap_lvl;
   logic       trig_lvl;
   int         gap;
   int         high;
   int         per;
   int         rises;
   int         fail_count;
   int         n_tests;
   int         cycles = 0;
   int         r0;
   word_t      v1;
   word_t      v2;
   logic [7:0] cmp_ctrl [4] = '{8'h08, 8'h18, 8'h20, 8'h1C};
   logic [3:0] pin_s = 4'b0011;
   logic [3:0] pin_e = 4'b1101;

   periodic_timer i_periodic_timer (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
      .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
      .o_avs_waitrequest(waitrequest), .o_avs_readdata(readdata),
      .i_capture_input_pin(cap), .i_ext_clock_trigger_pin(trig),
      .o_waveform_output_pin(pin), .o_waveform_output_oe(oe));

   periodic_timer_far_side i_periodic_timer_far_side (.i_clk(i_clk),
      .i_cap_lvl(cap_lvl), .i_trig_lvl(trig_lvl), .i_pin(pin), .i_oe(oe),
      .o_cap(cap), .o_trig(trig), .o_gap(gap), .o_high(high), .o_per(per),
      .o_rises(rises));

   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   task automatic stop_test();
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // a hang ends the run as a failure
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         stop_test();
      end
   end

   task automatic check(input string n, input word_t seen, input word_t exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
   endtask

   // one access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input addr_t a, input word_t d, output word_t q);
      write <= w;
      read <= ~w;
      address <= a;
      writedata <= d;
      @(posedge i_clk);
      while (waitrequest !== 1'b0)
         @(posedge i_clk);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic wr(input addr_t a, input logic [7:0] d);
      word_t q;
      bus(1'b1, a, {24'h000000, d}, q);
   endtask

   task automatic rd(input addr_t a, output word_t q);
      bus(1'b0, a, 32'h00000000, q);
   endtask

   task automatic chk_rd(input string n, input addr_t a, input word_t e);
      word_t q;
      rd(a, q);
      check(n, q, e);
   endtask

   task automatic set10(input addr_t lo, input count_t v);
      wr(lo, v[7:0]);
      wr(lo + 6'h04, {6'h00, v[9:8]});
   endtask

   // control changes only while stopped; pin action is unsafe mid-run
   task automatic start(input logic [7:0] c);
      wr(ADDR_RUN, 8'h00);
      wr(ADDR_CTRL, c);
      wr(ADDR_RUN, 8'h01);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   initial
   begin
      i_resetn = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      writedata = '0;
      byteenable = 4'hF;
      cap_lvl = 1'b0;
      trig_lvl = 1'b0;
      fail_count = 0;
      n_tests = 0;
      wait_clk(2);
      i_resetn <= 1'b1;
      check("oe", word_t'(oe), 32'h1);
      chk_rd("period_lo", ADDR_PERIOD_LO, 32'h0);
      chk_rd("period_hi", ADDR_PERIOD_HI, 32'h0);
      wr(ADDR_PERIOD_HI, 8'hFF);
      wr(ADDR_PERIOD_LO, 8'hA5);
      byteenable <= 4'h0;
      wr(ADDR_PERIOD_LO, 8'h11);
      byteenable <= 4'hF;
      chk_rd("period_hi", ADDR_PERIOD_HI, 32'h3);
      chk_rd("period_lo", ADDR_PERIOD_LO, 32'hA5);
      chk_rd("unmapped", 6'h3C, 32'h0);
      // compare mode: initial level, pin actions, polarity
      set10(ADDR_DUTY_LO, 10'h00A);
      set10(ADDR_PERIOD_LO, 10'h014);
      for (int k = 0; k < 4; k++)
      begin
         start(cmp_ctrl[k]);
         wait_clk(3);
         check("pin_start", word_t'(pin), word_t'(pin_s[k]));
         wait_clk(30);
         check("pin_end", word_t'(pin), word_t'(pin_e[k]));
      end
      start(8'h30);
      wr(ADDR_STATUS, 8'h03);
      wait_clk(70);
      check("toggle_gap", word_t'(gap), 32'd20);
      chk_rd("status", ADDR_STATUS, 32'h3);
      set10(ADDR_PERIOD_LO, 10'h005);
      start(8'h31);
      wr(ADDR_STATUS, 8'h03);
      wait_clk(50);
      chk_rd("status", ADDR_STATUS, 32'h1);
      check("duty_clear_gap", word_t'(gap), 32'd10);
      set10(ADDR_PERIOD_LO, 10'h014);
      start(8'hC0);
      wr(ADDR_STATUS, 8'h03);
      wait_clk(50);
      chk_rd("status", ADDR_STATUS, 32'h3);
      check("oe", word_t'(oe), 32'h0);
      // zero duty: full-range overflow, no duty match
      set10(ADDR_DUTY_LO, 10'h000);
      set10(ADDR_PERIOD_LO, 10'h000);
      start(8'h30);
      wr(ADDR_STATUS, 8'h03);
      r0 = rises;
      wait_clk(1100);
      rd(ADDR_STATUS, v1);
      check("duty_flag", v1 & 32'h1, 32'h0);
      check("rises", word_t'(rises), word_t'(r0));
      // pwm
      set10(ADDR_PERIOD_LO, 10'h008);
      set10(ADDR_DUTY_LO, 10'h003);
      start(8'hA8);
      wr(ADDR_STATUS, 8'h03);
      wait_clk(40);
      check("pwm_high", word_t'(high), 32'd3);
      check("pwm_period", word_t'(per), 32'd8);
      chk_rd("status", ADDR_STATUS, 32'h3);
      wr(ADDR_DUTY_LO, 8'h08);
      wait_clk(20);
      r0 = 0;
      repeat (16)
      begin
         @(posedge i_clk);
         if (pin !== 1'b1)
            r0++;
      end
      check("full_duty_lows", word_t'(r0), 32'd0);
      start(8'h88);
      wr(ADDR_STATUS, 8'h03);
      wait_clk(20);
      check("forced_off", word_t'(pin), 32'h0);
      chk_rd("status", ADDR_STATUS, 32'h3);
      start(8'h98);
      wait_clk(5);
      check("forced_on", word_t'(pin), 32'h1);
      set10(ADDR_PERIOD_LO, 10'h000);
      set10(ADDR_DUTY_LO, 10'h005);
      start(8'hA8);
      wait_clk(2100);
      check("pwm_period", word_t'(per), 32'd1024);
      // single pulse, period below duty is ignored
      set10(ADDR_PERIOD_LO, 10'h003);
      set10(ADDR_DUTY_LO, 10'h006);
      start(8'hB8);
      wr(ADDR_STATUS, 8'h03);
      wait_clk(20);
      // counter is zeroed one clock after timer_on rises, so the pulse is duty + 1 clocks
      check("pulse_width", word_t'(high), 32'd7);
      chk_rd("timer_on", ADDR_RUN, 32'h0);
      chk_rd("status", ADDR_STATUS, 32'h1);
      r0 = rises;
      trig_lvl <= 1'b1;
      wait_clk(3);
      trig_lvl <= 1'b0;
      wait_clk(20);
      check("trig_rises", word_t'(rises), word_t'(r0 + 1));
      check("trig_width", word_t'(high), 32'd7);
      // capture on both edges, exactly 100 clocks apart; period 0 so no wrap between them
      set10(ADDR_PERIOD_LO, 10'h000);
      start(8'h60);
      wr(ADDR_STATUS, 8'h03);
      r0 = cycles;
      cap_lvl <= 1'b1;
      wait_clk(10);
      rd(ADDR_DUTY_LO, v1);
      while (cycles < r0 + 100)
         @(posedge i_clk);
      cap_lvl <= 1'b0;
      wait_clk(10);
      rd(ADDR_DUTY_LO, v2);
      check("capture_diff", v2 - v1, 32'd100);
      rd(ADDR_STATUS, v1);
      check("capture_flag", v1 & 32'h1, 32'h1);
      start(8'h70);
      cap_lvl <= 1'b1;
      wait_clk(10);
      chk_rd("no_capture", ADDR_DUTY_LO, v2);
      cap_lvl <= 1'b0;
      set10(ADDR_DUTY_LO, 10'h000);
      set10(ADDR_PERIOD_LO, 10'h032);
      start(8'h42);
      cap_lvl <= 1'b1;
      wait_clk(10);
      chk_rd("wrong_source", ADDR_DUTY_LO, 32'h0);
      wr(ADDR_STATUS, 8'h03);
      trig_lvl <= 1'b1;
      wait_clk(10);
      rd(ADDR_DUTY_LO, v1);
      check("trig_capture", word_t'(v1 != 0), 32'h1);
      wait_clk(60);
      rd(ADDR_STATUS, v1);
      check("period_flag", (v1 >> 1) & 32'h1, 32'h1);
      rd(ADDR_COUNT_LO, v1);
      check("count_below", word_t'(v1 < 50), 32'h1);
      // prescaler: a tick every two clocks doubles every pwm width
      wr(ADDR_PRESCALE, 8'h01);
      chk_rd("prescale", ADDR_PRESCALE, 32'h1);
      set10(ADDR_DUTY_LO, 10'h00A);
      start(8'hA8);
      wait_clk(250);
      check("slow_period", word_t'(per), 32'd100);
      check("slow_high", word_t'(high), 32'd20);
      stop_test();
   end
endmodule // test_periodic_timer
